// ==== pkg/fcsm_pkg.sv ====
`default_nettype none
package fcsm_pkg;
   // command codes written on the data bus
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'hd0;
   localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
   localparam logic [7:0] CMD_PROT_SETUP = 8'hc0;
   // status field positions
   localparam int SEQ_READY_BIT = 7;
   localparam int PROG_SUSP_BIT = 2;
   // bus widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // bus cycle timing, in ns, and derived cycle counts at 50 MHz
   localparam int CLK_PERIOD_NS = 20;
   localparam int STROBE_NS = 100;
   localparam int RECOVER_NS = 60;
   localparam logic [3:0] STROBE_CYC =
      4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RECOVER_CYC =
      4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // host operations
   typedef enum logic [1:0] {
      FCSM_OP_SUSPEND = 2'b00,
      FCSM_OP_READ = 2'b01,
      FCSM_OP_RESUME = 2'b10,
      FCSM_OP_COMMAND = 2'b11
   } fcsm_op_t;
endpackage
`default_nettype wire

// ==== rtl/fcsm_bus_cycle.sv ====
`timescale 1ns/100ps
`default_nettype none
// one asynchronous flash bus cycle: write pulses we, read pulses ce and oe
module fcsm_bus_cycle (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic isWrite,
   input wire logic [fcsm_pkg::ADDR_W-1:0] addrIn,
   input wire logic [fcsm_pkg::DATA_W-1:0] dataIn,
   output logic done,
   output logic [fcsm_pkg::DATA_W-1:0] readData,
   output logic [fcsm_pkg::ADDR_W-1:0] flashAddr,
   output logic [fcsm_pkg::DATA_W-1:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [fcsm_pkg::DATA_W-1:0] flashDqIn,
   output logic flashCeN,
   output logic flashOeN,
   output logic flashWeN
);
   typedef enum logic [1:0] {
      BC_IDLE = 2'b00,
      BC_STROBE = 2'b01,
      BC_RECOVER = 2'b10
   } fcsm_bc_t;
   fcsm_bc_t state_r;
   logic [3:0] cnt_r;
   logic wr_r;
   logic [fcsm_pkg::DATA_W-1:0] s1_r, s2_r, s3_r;
   wire cntZero = (cnt_r == 4'h0);

   // read data passes three flops; last two agreeing take effect
   always_ff @(posedge core_clk) begin
      s1_r <= flashDqIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // strobe sequencer; ce and oe rise after every read so status refreshes
   always_ff @(posedge core_clk) begin
      done <= 1'b0;
      if (rst) begin
         state_r <= BC_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         flashCeN <= 1'b1;
         flashOeN <= 1'b1;
         flashWeN <= 1'b1;
         flashDqOe <= 1'b0;
         flashAddr <= '0;
         flashDqOut <= '0;
         readData <= '0;
      end else begin
         unique case (state_r)
            BC_IDLE: begin
               if (start) begin
                  wr_r <= isWrite;
                  flashAddr <= addrIn;
                  flashDqOut <= dataIn;
                  flashDqOe <= isWrite;
                  flashCeN <= 1'b0;
                  flashWeN <= ~isWrite;
                  flashOeN <= isWrite;
                  cnt_r <= fcsm_pkg::STROBE_CYC + 4'h3;
                  state_r <= BC_STROBE;
               end
            end
            BC_STROBE: begin
               if (cntZero) begin
                  if (!wr_r && s2_r == s3_r) begin
                     readData <= s3_r;
                  end
                  flashCeN <= 1'b1;
                  flashOeN <= 1'b1;
                  flashWeN <= 1'b1;
                  cnt_r <= fcsm_pkg::RECOVER_CYC;
                  state_r <= BC_RECOVER;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            BC_RECOVER: begin
               if (cntZero) begin
                  flashDqOe <= 1'b0;
                  done <= 1'b1;
                  state_r <= BC_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            default: state_r <= BC_IDLE;
         endcase
      end
   end
endmodule // fcsm_bus_cycle
`default_nettype wire

// ==== rtl/fcsm_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - host suspends by writing B0h then 70h to any address.
// - ready bit 7 high when sequencer ready; host polls it before other bits.
// - status refreshes only on chip or output enable toggle; host toggles them.
// - host may write FFh for array reads, avoiding the suspended block.
// - host writes D0h to resume programming after array reads.
module fcsm_host (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire logic [1:0] reqOp,
   input wire logic [fcsm_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [7:0] reqCmd,
   output logic reqReady,
   output logic rspValid,
   output logic [fcsm_pkg::DATA_W-1:0] rspData,
   output logic rspSuspended,
   output logic [fcsm_pkg::ADDR_W-1:0] flashAddr,
   output logic [fcsm_pkg::DATA_W-1:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [fcsm_pkg::DATA_W-1:0] flashDqIn,
   output logic flashCeN,
   output logic flashOeN,
   output logic flashWeN
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SUSP_WR = 3'b001,
      H_STAT_WR = 3'b010,
      H_POLL = 3'b011,
      H_ARRAY_WR = 3'b100,
      H_READ = 3'b101,
      H_WRITE = 3'b110,
      H_WAIT = 3'b111
   } fcsm_host_t;
   // lowest address bit that tells erase blocks apart; plain default, set per part
   localparam int BLOCK_LSB = 16;
   fcsm_host_t state_r, state_nxt, firstState;
   logic start_r, start_nxt, isWrite_r, isWrite_nxt, busDone;
   logic suspended_r, suspended_nxt, reqReady_nxt, rspValid_nxt;
   logic [fcsm_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [fcsm_pkg::ADDR_W-1:BLOCK_LSB] suspBlock_r, suspBlock_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [fcsm_pkg::DATA_W-1:0] busData, rspData_nxt;

   // ready and suspended flags decoded from polled status
   wire seqReady = busData[fcsm_pkg::SEQ_READY_BIT];
   wire progSusp = busData[fcsm_pkg::PROG_SUSP_BIT];
   wire opIsSuspend = reqOp == fcsm_pkg::FCSM_OP_SUSPEND;
   wire opIsRead = reqOp == fcsm_pkg::FCSM_OP_READ;
   wire opIsResume = reqOp == fcsm_pkg::FCSM_OP_RESUME;
   // array reads during suspend go through a read-array write first
   wire needArray = suspended_r && opIsRead;
   // the suspend request carries the address of the block being programmed;
   // reads aimed at that block would return busy data, so no bus cycle is run
   wire sameBlock = reqAddr[fcsm_pkg::ADDR_W-1:BLOCK_LSB] == suspBlock_r;
   wire guardHit = needArray && sameBlock;
   // command byte of the first write of each request
   wire [7:0] firstCmd = opIsSuspend ? fcsm_pkg::CMD_SUSPEND :
      needArray ? fcsm_pkg::CMD_READ_ARRAY :
      opIsResume ? fcsm_pkg::CMD_RESUME : reqCmd;

   // first step of each request
   always_comb begin
      if (opIsSuspend) begin
         firstState = H_SUSP_WR;
      end else if (guardHit) begin
         firstState = H_WAIT;
      end else if (needArray) begin
         firstState = H_ARRAY_WR;
      end else if (opIsRead) begin
         firstState = H_READ;
      end else begin
         firstState = H_WRITE;
      end
   end

   fcsm_bus_cycle u_bus (
      .core_clk(core_clk),
      .rst(rst),
      .start(start_r),
      .isWrite(isWrite_r),
      .addrIn(addr_r),
      .dataIn({8'h00, cmd_r}),
      .done(busDone),
      .readData(busData),
      .flashAddr(flashAddr),
      .flashDqOut(flashDqOut),
      .flashDqOe(flashDqOe),
      .flashDqIn(flashDqIn),
      .flashCeN(flashCeN),
      .flashOeN(flashOeN),
      .flashWeN(flashWeN)
   );

   // host sequencer: suspend, poll, array read, resume, raw command
   always_comb begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      isWrite_nxt = isWrite_r;
      addr_nxt = addr_r;
      cmd_nxt = cmd_r;
      rspValid_nxt = 1'b0;
      reqReady_nxt = reqReady;
      rspData_nxt = rspData;
      suspended_nxt = suspended_r;
      suspBlock_nxt = suspBlock_r;
      unique case (state_r)
         // take a request; a guarded read starts no bus cycle
         H_IDLE: begin
            if (reqValid) begin
               reqReady_nxt = 1'b0;
               addr_nxt = reqAddr;
               start_nxt = !guardHit;
               isWrite_nxt = !opIsRead || needArray;
               cmd_nxt = firstCmd;
               state_nxt = firstState;
            end
         end
         // suspend written; ask for status next
         H_SUSP_WR: begin
            if (busDone) begin
               cmd_nxt = fcsm_pkg::CMD_READ_STATUS;
               start_nxt = 1'b1;
               state_nxt = H_STAT_WR;
            end
         end
         // status mode set; start polling reads
         H_STAT_WR: begin
            if (busDone) begin
               isWrite_nxt = 1'b0;
               start_nxt = 1'b1;
               state_nxt = H_POLL;
            end
         end
         // each poll is a fresh ce/oe cycle, so the status word refreshes
         H_POLL: begin
            if (busDone && seqReady) begin
               suspended_nxt = progSusp;
               suspBlock_nxt = addr_r[fcsm_pkg::ADDR_W-1:BLOCK_LSB];
               rspData_nxt = busData;
               rspValid_nxt = 1'b1;
               reqReady_nxt = 1'b1;
               state_nxt = H_IDLE;
            end else if (busDone) begin
               start_nxt = 1'b1;
            end
         end
         // read-array mode set; now the array read itself
         H_ARRAY_WR: begin
            if (busDone) begin
               isWrite_nxt = 1'b0;
               start_nxt = 1'b1;
               state_nxt = H_READ;
            end
         end
         // read word handed back
         H_READ: begin
            if (busDone) begin
               rspData_nxt = busData;
               rspValid_nxt = 1'b1;
               reqReady_nxt = 1'b1;
               state_nxt = H_IDLE;
            end
         end
         // any write of the resume code ends the suspension
         H_WRITE: begin
            if (busDone) begin
               if (cmd_r == fcsm_pkg::CMD_RESUME) begin
                  suspended_nxt = 1'b0;
               end
               rspValid_nxt = 1'b1;
               reqReady_nxt = 1'b1;
               state_nxt = H_IDLE;
            end
         end
         // guarded read: answer at once, flash left untouched
         H_WAIT: begin
            rspValid_nxt = 1'b1;
            reqReady_nxt = 1'b1;
            state_nxt = H_IDLE;
         end
      endcase
   end

   // state and output registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= H_IDLE;
         start_r <= 1'b0;
         isWrite_r <= 1'b0;
         addr_r <= '0;
         cmd_r <= 8'h00;
         suspended_r <= 1'b0;
         suspBlock_r <= '0;
         reqReady <= 1'b1;
         rspValid <= 1'b0;
         rspData <= '0;
         rspSuspended <= 1'b0;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         isWrite_r <= isWrite_nxt;
         addr_r <= addr_nxt;
         cmd_r <= cmd_nxt;
         suspended_r <= suspended_nxt;
         suspBlock_r <= suspBlock_nxt;
         reqReady <= reqReady_nxt;
         rspValid <= rspValid_nxt;
         rspData <= rspData_nxt;
         rspSuspended <= suspended_nxt;
      end
   end
endmodule // fcsm_host
`default_nettype wire

// ==== test/fcsm_host_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// port checks on the host controller
module fcsm_host_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire logic [1:0] reqOp,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire logic [fcsm_pkg::DATA_W-1:0] flashDqOut,
   input wire logic flashDqOe,
   input wire logic flashCeN,
   input wire logic flashOeN,
   input wire logic flashWeN
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // handshake and response timing
   property p_pulse; rspValid |=> !rspValid; endproperty
   a_pulse: assert property (p_pulse) else $error("response pulse too long");
   property p_take; reqValid && reqReady |=> !reqReady; endproperty
   a_take: assert property (p_take) else $error("ready stayed after take");
   property p_ready; rspValid |-> reqReady; endproperty
   a_ready: assert property (p_ready) else $error("not ready at response");
   // strobe qualification on the flash pins
   property p_wr; !flashWeN |-> !flashCeN && flashDqOe && flashOeN; endproperty
   a_wr: assert property (p_wr) else $error("bad write strobe qualifiers");
   property p_rd; !flashOeN |-> !flashDqOe && !flashCeN; endproperty
   a_rd: assert property (p_rd) else $error("bad read strobe qualifiers");
   property p_wide; $fell(flashWeN) |-> !flashWeN [*5]; endproperty
   a_wide: assert property (p_wide) else $error("write strobe too short");
   property p_oeup; $fell(flashOeN) |-> ##[1:12] flashOeN; endproperty
   a_oeup: assert property (p_oeup) else $error("output enable not toggled");
   // suspend sequence: b0 then 70
   property p_susp;
      reqValid && reqReady && reqOp == 2'b00 |-> ##[1:3] (!flashWeN && flashDqOut == 16'h00b0);
   endproperty
   a_susp: assert property (p_susp) else $error("suspend write missing");
   property p_then;
      $rose(flashWeN) && flashDqOut == 16'h00b0 |-> ##[1:30] (!flashWeN && flashDqOut == 16'h0070);
   endproperty
   a_then: assert property (p_then) else $error("status command missing");
   c_susp: cover property (reqValid && reqReady && reqOp == 2'b00);
   c_read: cover property (!flashOeN);
   c_done: cover property ($rose(rspValid));
endmodule // fcsm_host_sva
`default_nettype wire

// ==== test/fcsm_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// behavioural flash: command states, status polls, array words
module fcsm_flash_model (
   input wire logic [fcsm_pkg::ADDR_W-1:0] flashAddr,
   input wire logic [fcsm_pkg::DATA_W-1:0] flashDqOut,
   input wire logic flashCeN,
   input wire logic flashOeN,
   input wire logic flashWeN,
   input wire logic doneMode,
   output logic [fcsm_pkg::DATA_W-1:0] flashDqIn,
   output var logic [4:0] devState
);
   // states: 00 array, 01 status, 02 config, 03 query, 04 lock setup,
   // 05 command error (lock or erase), 06 program busy, 07 program-suspend status,
   // 08 program-suspend array, 09 program done, 0a protection setup,
   // 0b/0c program-suspend config/query, 0d erase setup, 0e erase busy,
   // 0f erase-suspend status, 10 erase-suspend array, 11/12 erase-suspend config/query
   logic [15:0] shown = 16'h0000;
   int pend = 0;
   initial devState = 5'h06;
   // command decode on the end of each write strobe
   always @(posedge flashWeN) begin : wr
      logic [7:0] c;
      c = flashDqOut[7:0];
      case (devState)
         5'h06: if (c == 8'hb0) begin
            devState = doneMode ? 5'h09 : 5'h07;
            pend = 3;
         end
         5'h0e: if (c == 8'hb0) begin
            devState = 5'h0f;
            pend = 3;
         end
         5'h04: devState = (c == 8'h01 || c == 8'h2f || c == 8'hd0) ? 5'h00 : 5'h05;
         5'h0d: devState = (c == 8'hd0) ? 5'h0e : 5'h05;
         5'h07, 5'h08, 5'h0b, 5'h0c: devState = (c == 8'hd0) ? 5'h06 :
            (c == 8'h70) ? 5'h07 : (c == 8'h90) ? 5'h0b :
            (c == 8'h98) ? 5'h0c : 5'h08;
         5'h0f, 5'h10, 5'h11, 5'h12: devState = (c == 8'hd0) ? 5'h0e :
            (c == 8'h60) ? 5'h04 : (c == 8'h70) ? 5'h0f : (c == 8'h90) ? 5'h11 :
            (c == 8'h98) ? 5'h12 : 5'h10;
         default: devState = (c == 8'h60) ? 5'h04 : (c == 8'h90) ? 5'h02 :
            (c == 8'h98) ? 5'h03 : (c == 8'hc0) ? 5'h0a : (c == 8'h70) ? 5'h01 :
            (c == 8'h20) ? 5'h0d : 5'h00;
      endcase
   end
   // status refreshes only when output enable falls
   always @(negedge flashOeN) begin
      if (devState inside {5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0d, 5'h0e, 5'h0f}) begin
         shown = (pend > 0 || devState == 5'h06 || devState == 5'h0e) ? 16'h0000 :
            {8'h00, 1'b1, 4'h0, devState == 5'h07, 2'b00};
         if (pend > 0) pend--;
      end else shown = flashAddr[15:0] ^ 16'h5a5a;
   end
   // released bus shows the inverse of the last word
   assign flashDqIn = (!flashCeN && !flashOeN) ? shown : ~shown;
endmodule // fcsm_flash_model
`default_nettype wire

// ==== test/test_flash_command_state_machine.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_flash_command_state_machine;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic [1:0] reqOp = 2'b00;
   logic [fcsm_pkg::ADDR_W-1:0] reqAddr = 24'h000000;
   logic [7:0] reqCmd = 8'h00;
   logic doneMode = 1'b0;
   logic reqReady, rspValid, rspSuspended, flashDqOe, flashCeN, flashOeN, flashWeN;
   logic [fcsm_pkg::DATA_W-1:0] rspData, flashDqOut, flashDqIn;
   logic [fcsm_pkg::ADDR_W-1:0] flashAddr;
   logic [4:0] devState;
   int errors = 0;
   int n_checks = 0;
   always #10 core_clk = ~core_clk;
   fcsm_host u_dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqCmd(reqCmd), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .rspSuspended(rspSuspended), .flashAddr(flashAddr),
      .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
      .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
   fcsm_flash_model u_mod (.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashCeN(flashCeN),
      .flashOeN(flashOeN), .flashWeN(flashWeN), .doneMode(doneMode), .flashDqIn(flashDqIn),
      .devState(devState));
   // compare one word
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one request, then wait for the response pulse
   task op(input logic [1:0] o, input logic [23:0] a, input logic [7:0] c);
      int n;
      @(negedge core_clk);
      reqValid = 1'b1;
      reqOp = o;
      reqAddr = a;
      reqCmd = c;
      @(negedge core_clk);
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 500) begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, rspValid, 1'b1);
      end
   endtask
   task wr(input logic [7:0] c, input logic [4:0] e);
      op(2'b11, 24'h000200, c);
      chk({11'h000, devState}, {11'h000, e});
   endtask
   task t_suspend;
      op(2'b00, 24'h000100, 8'h00);
      chk({15'h0000, rspSuspended}, 16'h0001);
      chk(rspData & 16'h0084, 16'h0084);
      chk({11'h000, devState}, 16'h0007);
      $display("t_suspend done");
   endtask
   // a read into the suspended block must not reach the flash
   task t_guard;
      op(2'b01, 24'h000100, 8'h00);
      chk({11'h000, devState}, 16'h0007);
      chk({15'h0000, rspSuspended}, 16'h0001);
      $display("t_guard done");
   endtask
   task t_read;
      op(2'b01, 24'h021234, 8'h00);
      chk(rspData, 16'h1234 ^ 16'h5a5a);
      chk({11'h000, devState}, 16'h0008);
      $display("t_read done");
   endtask
   // config, query, status and protection codes while programming is suspended
   task t_psusp;
      wr(8'h90, 5'h0b);
      wr(8'h98, 5'h0c);
      wr(8'h70, 5'h07);
      wr(8'hc0, 5'h08);
      wr(8'h90, 5'h0b);
      chk({15'h0000, rspSuspended}, 16'h0001);
      $display("t_psusp done");
   endtask
   task t_resume;
      op(2'b10, 24'h000100, 8'h00);
      chk({15'h0000, rspSuspended}, 16'h0000);
      chk({11'h000, devState}, 16'h0006);
      $display("t_resume done");
   endtask
   task t_done;
      doneMode = 1'b1;
      op(2'b00, 24'h000100, 8'h00);
      chk({15'h0000, rspSuspended}, 16'h0000);
      chk(rspData & 16'h0084, 16'h0080);
      $display("t_done done");
   endtask
   task t_lock;
      wr(8'h60, 4'h4);
      wr(8'h2f, 4'h0);
      wr(8'h60, 4'h4);
      wr(8'h70, 4'h5);
      wr(8'hd0, 4'h0);
      wr(8'h90, 4'h2);
      wr(8'h98, 5'h03);
      $display("t_lock done");
   endtask
   // erase setup errors, busy erase, erase suspend and its command column
   task t_erase;
      wr(8'h20, 5'h0d);
      wr(8'h70, 5'h05);
      wr(8'h20, 5'h0d);
      wr(8'hd0, 5'h0e);
      wr(8'h90, 5'h0e);
      op(2'b00, 24'h000100, 8'h00);
      chk({11'h000, devState}, 16'h000f);
      chk(rspData & 16'h0084, 16'h0080);
      wr(8'hc0, 5'h10);
      wr(8'h98, 5'h12);
      wr(8'hd0, 5'h0e);
      op(2'b00, 24'h000100, 8'h00);
      chk({15'h0000, rspSuspended}, 16'h0000);
      wr(8'h60, 5'h04);
      wr(8'hd0, 5'h00);
      wr(8'hc0, 5'h0a);
      $display("t_erase done");
   endtask
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      t_suspend;
      t_guard;
      t_read;
      t_psusp;
      t_resume;
      t_done;
      t_lock;
      t_erase;
      final_report;
   end
   // hang guard, well beyond the expected run
   initial begin
      #200000;
      errors++;
      final_report;
   end
endmodule // test_flash_command_state_machine
bind fcsm_host fcsm_host_sva u_sva (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
   .reqOp(reqOp), .reqReady(reqReady), .rspValid(rspValid), .flashDqOut(flashDqOut),
   .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
`default_nettype wire
